// [verilog/flash_params.svh]
// constants shared by both ends of the flash status link
// assumes a 200 MHz mclk; included by bare name
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH

// link widths and address split (4 banks of 4 sectors of 256 words)
`define AW             12
`define DW             16
`define BANK_LSB       10
`define SEC_LSB        8
`define NSEC           16

// status bit positions on the data word
`define DATA_POLL_POS  7
`define TOGGLE1_POS    6
`define TIMEOUT_POS    5
`define ETIMER_POS     3
`define TOGGLE2_POS    2

// command codes, low byte of a write
`define CMD_PROGRAM    8'hA0
`define CMD_SERASE     8'h30
`define CMD_SUSPEND    8'hB0
`define CMD_RESUME     8'h3A
`define CMD_RESET      8'hF0

// timing
`define CLK_NS         5
`define ACC_NS         70
`define SLEEP_EXTRA_NS 60
`define SLEEP_CYC      ((`ACC_NS + `SLEEP_EXTRA_NS + `CLK_NS - 1) / `CLK_NS)
`define ERASE_WIN_NS   50000
`define ERASE_WIN_CYC  (`ERASE_WIN_NS / `CLK_NS)
`define PROG_NS        8000
`define PROG_CYC       (`PROG_NS / `CLK_NS)
`define ERASE_NS       200000000
`define ERASE_CYC      (`ERASE_NS / `CLK_NS)
`define PROG_LIMIT     (2 * `PROG_CYC)
`define ERASE_LIMIT    (2 * `ERASE_CYC)

// controller register offsets and fields
`define REG_CTRL       8'h00
`define REG_ADDR       8'h04
`define REG_WDATA      8'h08
`define REG_RDATA      8'h0C
`define REG_STATUS     8'h10
`define REG_IRQ_STAT   8'h14
`define REG_IRQ_CLR    8'h18
`define REG_IRQ_EN     8'h1C
`define CTRL_RST_POS   8
`define IRQ_DONE       0
`define IRQ_FAIL       1
`define IRQ_REJECT     2

`endif

// [verilog/flash_pkg.sv]
// types shared by the flash device end and its controller end
// assumes flash_params.svh for all numeric constants
package flash_pkg;
	typedef enum logic [7:0] {
		D_READ  = 8'h01,
		D_PSET  = 8'h02,
		D_PROG  = 8'h04,
		D_EWIN  = 8'h08,
		D_ERASE = 8'h10,
		D_SUSP  = 8'h20,
		D_SPSET = 8'h40,
		D_SPROG = 8'h80
	} dev_state_e;

	typedef enum logic [4:0] {
		H_IDLE = 5'h01,
		H_RD   = 5'h02,
		H_RW   = 5'h04,
		H_WR   = 5'h08,
		H_EVAL = 5'h10
	} host_state_e;

	typedef enum logic [2:0] {
		OP_NONE  = 3'h0,
		OP_READ  = 3'h1,
		OP_WRITE = 3'h2,
		OP_POLL  = 3'h3,
		OP_EADD  = 3'h4
	} host_op_e;
endpackage : flash_pkg

// [verilog/flash_link_if.sv]
// link between the flash device end and the controller end
// assumes both ends run on the same mclk
`timescale 1ns/1ps
`include "flash_params.svh"
interface flash_link_if;
	logic             hw_reset_n;
	logic             rd_en;
	logic             burst;
	logic             wr_en;
	logic [`AW-1:0]   addr;
	logic [`DW-1:0]   wdata;
	logic [`DW-1:0]   rdata;
	logic             rdy;
	logic             sleeping;

	modport dev_mp (input hw_reset_n, rd_en, burst, wr_en, addr, wdata,
		output rdata, rdy, sleeping);
	modport host_mp (output hw_reset_n, rd_en, burst, wr_en, addr, wdata,
		input rdata, rdy, sleeping);
endinterface : flash_link_if

// [verilog/flash_status_dev.sv]
// flash device end: array, command decode, embedded program/erase, status
// assumes the controller drives the link synchronously to mclk
`timescale 1ns/1ps
`include "flash_params.svh"
module flash_status_dev #(
	parameter int unsigned ERASE_WIN_CYC = `ERASE_WIN_CYC,
	parameter int unsigned ERASE_CYC     = `ERASE_CYC,
	parameter int unsigned ERASE_LIMIT   = `ERASE_LIMIT
) (
	// clock and reset
	input  wire logic  mclk,
	input  wire logic  sys_rst,
	// link to the controller
	flash_link_if.dev_mp link
);
	import flash_pkg::*;

	localparam int unsigned PROG_CYC   = `PROG_CYC;
	localparam int unsigned PROG_LIMIT = `PROG_LIMIT;
	localparam int unsigned SLEEP_CYC  = `SLEEP_CYC;

	logic [`DW-1:0]   mem [0:(1<<`AW)-1];
	dev_state_e       state;
	logic [31:0]      op_cnt;
	logic [31:0]      win_cnt;
	logic [`NSEC-1:0] erase_set;
	logic [`AW-1:0]   prog_addr;
	logic [`DW-1:0]   prog_data;
	logic             timeout_flag;
	logic             tog1;
	logic             tog2;
	logic [`AW:0]     erase_ptr;
	logic             b_active;
	logic [`AW-1:0]   b_addr;
	logic [`AW-1:0]   rd_a;
	logic             rd_fire;
	logic [`DW-1:0]   rd_word;
	logic             status_sel;
	logic             rd_in_set;
	logic             prog_ok;
	logic             prog_commit;
	logic             erase_wr;
	logic             erase_done;
	logic [7:0]       cmd;
	logic [`AW-1:0]   addr_last;
	logic [7:0]       idle_cnt;

	function automatic logic [3:0] sec_of(input logic [`AW-1:0] a);
		sec_of = a[`AW-1:`SEC_LSB];
	endfunction : sec_of

	function automatic logic [1:0] bank_of(input logic [`AW-1:0] a);
		bank_of = a[`AW-1:`BANK_LSB];
	endfunction : bank_of

	// power-up array reads as erased
	initial begin
		for (int i = 0; i < (1 << `AW); i++) begin
			mem[i] = 16'hFFFF;
		end
	end

	assign cmd         = link.wdata[7:0];
	assign prog_ok     = (mem[prog_addr] & prog_data) == prog_data;
	assign prog_commit = (state == D_PROG || state == D_SPROG) && !timeout_flag && prog_ok
		&& op_cnt >= PROG_CYC - 1;
	assign erase_wr    = state == D_ERASE && !erase_ptr[`AW] && !timeout_flag;
	assign erase_done  = erase_ptr[`AW] && op_cnt >= ERASE_CYC - 1;

	// read address: latched burst pointer or the live address
	assign rd_a    = b_active ? b_addr : link.addr;
	assign rd_fire = link.rd_en && (!link.burst || b_active);
	assign rd_in_set = erase_set[sec_of(rd_a)];

	// status word mux; the busy bank returns status, in suspend only the suspended sectors; others array data
	always_comb begin
		rd_word    = mem[rd_a];
		status_sel = 1'b0;
		case (state)
			D_PROG, D_SPROG: begin
				if (bank_of(rd_a) == bank_of(prog_addr)) begin
					status_sel = 1'b1;
					rd_word    = 16'h0000;
					rd_word[`DATA_POLL_POS] = ~prog_data[`DATA_POLL_POS];
					rd_word[`TOGGLE1_POS]   = tog1;
					rd_word[`TIMEOUT_POS]   = timeout_flag;
					rd_word[`TOGGLE2_POS]   = tog2;
				end
			end
			D_EWIN, D_ERASE: begin
				if (|erase_set[bank_of(rd_a)*4 +: 4]) begin
					status_sel = 1'b1;
					rd_word    = 16'h0000;
					rd_word[`TOGGLE1_POS] = tog1;
					rd_word[`TIMEOUT_POS] = timeout_flag;
					rd_word[`ETIMER_POS]  = state == D_ERASE;
					rd_word[`TOGGLE2_POS] = tog2;
				end
			end
			D_SUSP: begin
				if (rd_in_set) begin
					status_sel = 1'b1;
					rd_word    = 16'h0000;
					rd_word[`DATA_POLL_POS] = 1'b1;
					rd_word[`TOGGLE1_POS]   = tog1;
					rd_word[`TOGGLE2_POS]   = tog2;
				end
			end
			default: begin
				rd_word = mem[rd_a];
			end
		endcase
	end

	// toggle bits flip only on status reads, so a poller sees them settle
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tog1 <= 1'b0;
			tog2 <= 1'b0;
		end else if (rd_fire && status_sel) begin
			if (state != D_SUSP) begin
				tog1 <= ~tog1;
			end
			if ((state == D_EWIN || state == D_ERASE || state == D_SUSP) && rd_in_set) begin
				tog2 <= ~tog2;
			end
		end
	end

	// read port: same path in every state, suspend included
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			b_active   <= 1'b0;
			b_addr     <= 12'h000;
			link.rdata <= 16'h0000;
			link.rdy   <= 1'b0;
		end else begin
			link.rdy <= rd_fire;
			if (rd_fire) begin
				link.rdata <= rd_word;
			end
			if (!link.rd_en || !link.burst || !link.hw_reset_n) begin
				b_active <= 1'b0;
			end else if (!b_active) begin
				b_active <= 1'b1; // initial access costs one wait cycle
				b_addr   <= link.addr;
			end else begin
				b_addr <= b_addr + 12'h001;
			end
		end
	end

	// embedded operation sequencer
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state        <= D_READ;
			op_cnt       <= 32'h0000_0000;
			win_cnt      <= 32'h0000_0000;
			erase_set    <= 16'h0000;
			prog_addr    <= 12'h000;
			prog_data    <= 16'h0000;
			timeout_flag <= 1'b0;
			erase_ptr    <= 13'h0000;
		end else if (!link.hw_reset_n) begin
			state        <= D_READ;
			erase_set    <= 16'h0000;
			timeout_flag <= 1'b0;
		end else begin
			case (state)
				D_READ: begin
					if (link.wr_en && cmd == `CMD_PROGRAM) begin
						state <= D_PSET;
					end else if (link.wr_en && cmd == `CMD_SERASE) begin
						state     <= D_EWIN;
						erase_set <= 16'h0001 << sec_of(link.addr);
						win_cnt   <= 32'h0000_0000;
					end
				end
				D_PSET, D_SPSET: begin
					if (link.wr_en) begin
						prog_addr <= link.addr;
						prog_data <= link.wdata;
						op_cnt    <= 32'h0000_0000;
						state     <= (state == D_PSET) ? D_PROG : D_SPROG;
					end
				end
				D_PROG, D_SPROG: begin
					op_cnt <= op_cnt + 32'h0000_0001;
					if (op_cnt >= PROG_LIMIT - 1) begin
						timeout_flag <= 1'b1;
					end
					if (prog_commit || (timeout_flag && link.wr_en && cmd == `CMD_RESET)) begin
						timeout_flag <= 1'b0;
						state        <= (state == D_PROG) ? D_READ : D_SUSP;
					end
				end
				D_EWIN: begin
					if (link.wr_en && cmd == `CMD_SERASE) begin
						erase_set <= erase_set | (16'h0001 << sec_of(link.addr));
						win_cnt   <= 32'h0000_0000;
					end else if (link.wr_en && cmd == `CMD_SUSPEND) begin
						state     <= D_SUSP;
						op_cnt    <= 32'h0000_0000; // resume must start a fresh walk
						erase_ptr <= 13'h0000;
					end else if (win_cnt >= ERASE_WIN_CYC - 1) begin
						state     <= D_ERASE;
						op_cnt    <= 32'h0000_0000;
						erase_ptr <= 13'h0000;
					end else begin
						win_cnt <= win_cnt + 32'h0000_0001;
					end
				end
				D_ERASE: begin
					op_cnt <= op_cnt + 32'h0000_0001;
					if (erase_wr) begin
						erase_ptr <= erase_ptr + 13'h0001;
					end
					if (op_cnt >= ERASE_LIMIT - 1) begin
						timeout_flag <= 1'b1;
					end
					if (link.wr_en && cmd == `CMD_SUSPEND && !timeout_flag) begin
						state <= D_SUSP;
					end else if ((erase_done && !timeout_flag)
						|| (timeout_flag && link.wr_en && cmd == `CMD_RESET)) begin
						state        <= D_READ;
						erase_set    <= 16'h0000;
						timeout_flag <= 1'b0;
					end
				end
				D_SUSP: begin
					if (link.wr_en && cmd == `CMD_RESUME) begin
						state <= D_ERASE;
					end else if (link.wr_en && cmd == `CMD_PROGRAM) begin
						state <= D_SPSET;
					end
				end
				default: begin
					state <= D_READ;
				end
			endcase
		end
	end

	// array writes: program commit clears bits, erase walk sets words
	// plain always: the power-up fill writes the array as well
	always @(posedge mclk) begin
		if (prog_commit) begin
			mem[prog_addr] <= mem[prog_addr] & prog_data;
		end else if (erase_wr && erase_set[sec_of(erase_ptr[`AW-1:0])]) begin
			mem[erase_ptr[`AW-1:0]] <= 16'hFFFF;
		end
	end

	// automatic sleep once the address has been still long enough
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			addr_last     <= 12'h000;
			idle_cnt      <= 8'h00;
			link.sleeping <= 1'b0;
		end else begin
			addr_last <= link.addr;
			if (link.addr != addr_last || link.rd_en || link.wr_en) begin
				idle_cnt      <= 8'h00;
				link.sleeping <= 1'b0;
			end else if (idle_cnt >= 8'(SLEEP_CYC - 1)) begin
				link.sleeping <= 1'b1;
			end else begin
				idle_cnt <= idle_cnt + 8'h01;
			end
		end
	end

endmodule : flash_status_dev

// [verilog/flash_status_host.sv]
// controller end: AXI4-Lite registers, runs reads, writes and status polls
// assumes one mclk shared with the device and the AXI master
`timescale 1ns/1ps
`include "flash_params.svh"
module flash_status_host (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// interrupt
	output logic             irq,
	// link to the device
	flash_link_if.host_mp    link
);
	import flash_pkg::*;

	host_state_e    state;
	host_op_e       op;
	logic [1:0]     phase;
	logic [`AW-1:0] addr_r;
	logic [`DW-1:0] wdata_r;
	logic [`DW-1:0] rdata_r;
	logic           prev_t1;
	logic           reset_bit;
	logic [2:0]     irq_stat;
	logic [2:0]     irq_en;
	logic [2:0]     ev;
	logic           wr_go;
	logic           rd_go;
	logic           start;

	// take address and data together; one response outstanding at a time
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = rd_go;
	assign start = wr_go && s_axi_awaddr == `REG_CTRL && s_axi_wstrb[0] && state == H_IDLE;

	// link drive: strobes straight from the state
	assign link.rd_en      = state == H_RD;
	assign link.wr_en      = state == H_WR;
	assign link.burst      = 1'b0;
	assign link.addr       = addr_r;
	assign link.wdata      = wdata_r;
	assign link.hw_reset_n = ~reset_bit;
	assign irq             = |(irq_stat & irq_en);

	// register writes and read answers
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= 2'b00;
			s_axi_rdata  <= 32'h0000_0000;
			addr_r       <= 12'h000;
			wdata_r      <= 16'h0000;
			reset_bit    <= 1'b0;
			irq_en       <= 3'h0;
		end else begin
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'b00;
				case (s_axi_awaddr)
					`REG_CTRL: reset_bit <= s_axi_wdata[`CTRL_RST_POS];
					`REG_ADDR: addr_r <= s_axi_wdata[`AW-1:0];
					`REG_WDATA: wdata_r <= s_axi_wdata[`DW-1:0];
					`REG_IRQ_EN: irq_en <= s_axi_wdata[2:0];
					`REG_IRQ_CLR, `REG_RDATA, `REG_STATUS, `REG_IRQ_STAT: begin
						s_axi_bresp <= 2'b00;
					end
					default: s_axi_bresp <= 2'b10;
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'b00;
				case (s_axi_araddr)
					`REG_CTRL: s_axi_rdata <= {23'h0, reset_bit, 5'h0, op};
					`REG_ADDR: s_axi_rdata <= {20'h0, addr_r};
					`REG_WDATA: s_axi_rdata <= {16'h0, wdata_r};
					`REG_RDATA: s_axi_rdata <= {16'h0, rdata_r};
					`REG_STATUS: s_axi_rdata <= {31'h0, state != H_IDLE};
					`REG_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat};
					`REG_IRQ_EN: s_axi_rdata <= {29'h0, irq_en};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end
		end
	end

	// sticky events; a new event wins over a clear in the same cycle
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_stat <= 3'h0;
		end else begin
			irq_stat <= (irq_stat & ~((wr_go && s_axi_awaddr == `REG_IRQ_CLR)
				? s_axi_wdata[2:0] : 3'h0)) | ev;
		end
	end

	// operation sequencer
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state   <= H_IDLE;
			op      <= OP_NONE;
			phase   <= 2'd0;
			rdata_r <= 16'h0000;
			prev_t1 <= 1'b0;
			ev      <= 3'h0;
		end else begin
			ev <= 3'h0;
			case (state)
				H_IDLE: begin
					if (start) begin
						op    <= host_op_e'(s_axi_wdata[2:0]);
						phase <= 2'd0;
						state <= (s_axi_wdata[2:0] == OP_WRITE) ? H_WR : H_RD;
					end
				end
				H_RD: state <= H_RW;
				H_RW: begin
					if (link.rdy) begin
						rdata_r <= link.rdata;
						state   <= H_EVAL;
					end
				end
				H_WR: state <= H_EVAL;
				H_EVAL: begin
					state <= H_IDLE;
					case (op)
						OP_POLL: begin
							prev_t1 <= rdata_r[`TOGGLE1_POS];
							if (phase == 2'd0) begin
								phase <= 2'd1;
								state <= H_RD;
							end else if (rdata_r[`TOGGLE1_POS] == prev_t1) begin
								ev[`IRQ_DONE] <= 1'b1;
							end else if (phase == 2'd2) begin
								ev[`IRQ_FAIL] <= 1'b1;
							end else begin
								phase <= rdata_r[`TIMEOUT_POS] ? 2'd2 : 2'd1;
								state <= H_RD;
							end
						end
						OP_EADD: begin
							if (phase == 2'd1) begin
								phase <= 2'd2;
								state <= H_RD;
							end else if (rdata_r[`ETIMER_POS]) begin
								ev[`IRQ_REJECT] <= 1'b1;
							end else if (phase == 2'd0) begin
								phase <= 2'd1;
								state <= H_WR;
							end else begin
								ev[`IRQ_DONE] <= 1'b1;
							end
						end
						default: ev[`IRQ_DONE] <= 1'b1;
					endcase
				end
				default: state <= H_IDLE;
			endcase
		end
	end

endmodule : flash_status_host

// [sim/flash_status_checker.sv]
// assertions on the flash status link between controller and device
// assumes one mclk domain; inputs come straight from the link interface
`timescale 1ns/1ps
`include "flash_params.svh"
module flash_status_checker (
	// clock and reset
	input wire logic           mclk,
	input wire logic           sys_rst,
	// link signals
	input wire logic           hw_reset_n,
	input wire logic           rd_en,
	input wire logic           burst,
	input wire logic           wr_en,
	input wire logic [`AW-1:0] addr,
	input wire logic [`DW-1:0] wdata,
	input wire logic [`DW-1:0] rdata,
	input wire logic           rdy,
	input wire logic           sleeping
);
	localparam int SLEEP_LIM = `SLEEP_CYC + 3;
	logic        armed;
	logic        seen_erase;
	logic        have_prev;
	logic        pd7;
	logic        prev6;
	logic        prev2;
	logic [1:0]  pbank;
	logic [1:0]  rbank;
	logic [11:0] pcnt;
	logic [7:0]  scnt;
	logic        prog_on;
	logic        st_rd;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// command tracking; programs after an erase may be ignored, so they are not judged
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst || !hw_reset_n) begin
			armed      <= 1'b0;
			seen_erase <= 1'b0;
		end else if (wr_en) begin
			armed      <= !armed && wdata[7:0] == `CMD_PROGRAM;
			seen_erase <= seen_erase || wdata[7:0] == `CMD_SERASE;
		end
	end

	// program window, kept short of the program time so status is certain
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pcnt  <= '1;
			pbank <= '0;
			pd7   <= 1'b0;
		end else if (wr_en && armed && !seen_erase) begin
			pcnt  <= '0;
			pbank <= addr[11:10];
			pd7   <= wdata[7];
		end else if (pcnt != '1) begin
			pcnt <= pcnt + 1'b1;
		end
	end
	assign prog_on = pcnt < 12'd1500;
	assign st_rd   = rdy && prog_on && rbank == pbank;

	// bank of the read in flight
	always_ff @(posedge mclk) begin
		if (rd_en) begin
			rbank <= addr[11:10];
		end
	end

	// last status word seen during the program
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst || !prog_on) begin
			have_prev <= 1'b0;
		end else if (st_rd) begin
			have_prev <= 1'b1;
			prev6     <= rdata[6];
			prev2     <= rdata[2];
		end
	end

	// quiet cycles with a stable address
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			scnt <= '0;
		end else if (rd_en || wr_en || !hw_reset_n || $changed(addr)) begin
			scnt <= '0;
		end else if (scnt != 8'hFF) begin
			scnt <= scnt + 1'b1;
		end
	end

	sequence s_next_status;
		st_rd && have_prev;
	endsequence
	property p_read_answer;  rd_en && !burst |=> rdy; endproperty
	property p_no_stray;     !rd_en |=> !rdy; endproperty
	property p_prog_poll;    st_rd |-> rdata[7] == !pd7; endproperty
	property p_prog_flags;   st_rd |-> rdata[5] == 1'b0 && rdata[3] == 1'b0; endproperty
	property p_prog_toggle;  s_next_status |-> rdata[6] != prev6; endproperty
	property p_prog_t2;      s_next_status |-> rdata[2] == prev2; endproperty
	property p_sleep_on;     scnt >= SLEEP_LIM |-> sleeping; endproperty
	property p_sleep_off;    $changed(addr) |-> ##[1:2] !sleeping; endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");
	a_no_stray: assert property (p_no_stray) else $error("ready without read");
	a_prog_poll: assert property (p_prog_poll) else $error("poll bit wrong");
	a_prog_flags: assert property (p_prog_flags) else $error("timeout or timer set");
	a_prog_toggle: assert property (p_prog_toggle) else $error("toggle one static");
	a_prog_t2: assert property (p_prog_t2) else $error("toggle two moved");
	a_sleep_on: assert property (p_sleep_on) else $error("no sleep");
	a_sleep_off: assert property (p_sleep_off) else $error("sleep kept");
endmodule : flash_status_checker

// [sim/tb_top.sv]
// bench: controller and device joined by the link, driven over axi4-lite
// assumes a 200 MHz mclk and shortened erase timing on the device
`timescale 1ns/1ps
`include "flash_params.svh"
module tb_top;
	typedef struct {logic [33:0] e; logic [33:0] m; string nm;} note_s;
	logic        mclk, sys_rst, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, lfsr, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [15:0] d;
	int          num_errors, check_count;
	note_s       q[$];

	flash_link_if link ();
	flash_status_dev #(.ERASE_WIN_CYC(200), .ERASE_CYC(10), .ERASE_LIMIT(10000))
		flash_status_dev_inst (.mclk, .sys_rst, .link);
	flash_status_host flash_status_host_inst (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .link);
	flash_status_checker flash_status_checker_inst (.mclk, .sys_rst,
		.hw_reset_n(link.hw_reset_n), .rd_en(link.rd_en), .burst(link.burst),
		.wr_en(link.wr_en), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
		.rdy(link.rdy), .sleeping(link.sleeping));

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next

	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict

	task automatic hang(input string nm);
		num_errors++;
		$display("BAD %s expected answer seen timeout", nm);
		print_verdict();
	endtask : hang

	// write: both channels offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, b;
		b = 1'b0;
		@(posedge mclk);
		s_axi_awaddr  <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= v;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (int n = 0; !b; n++) begin
			@(negedge mclk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			b  = s_axi_bvalid;
			@(posedge mclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
			if (n > 500) hang("axi write");
		end
	endtask : axi_wr

	// read: the expectation is noted first, the monitor compares it
	task automatic axi_rd(input logic [7:0] a, input logic [33:0] e, m, input string nm);
		logic ta, r;
		r = 1'b0;
		q.push_back('{e, m, nm});
		@(posedge mclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (int n = 0; !r; n++) begin
			@(negedge mclk);
			ta = s_axi_arready;
			r  = s_axi_rvalid;
			rd = s_axi_rdata;
			@(posedge mclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (r) s_axi_rready <= 1'b0;
			if (n > 500) hang("axi read");
		end
	endtask : axi_rd

	// start a controller operation and wait until it is no longer busy
	task automatic do_op(input logic [31:0] op);
		axi_wr(`REG_CTRL, op);
		rd = 32'h1;
		for (int n = 0; rd[0] !== 1'b0; n++) begin
			axi_rd(`REG_STATUS, '0, '0, "busy");
			if (n > 5000) hang("operation");
		end
	endtask : do_op

	task automatic link_wr(input logic [11:0] a, input logic [15:0] v, input logic [31:0] op);
		axi_wr(`REG_ADDR, {20'h0, a});
		axi_wr(`REG_WDATA, {16'h0, v});
		do_op(op);
	endtask : link_wr

	task automatic link_rd(input logic [11:0] a, input logic [15:0] e, m, input string nm);
		axi_wr(`REG_ADDR, {20'h0, a});
		do_op(32'h1);
		axi_rd(`REG_RDATA, {18'h0, e & m}, {2'h3, 16'h0, m}, nm);
	endtask : link_rd

	// interrupt status read, then cleared
	task automatic irq_take(input logic [2:0] e);
		axi_rd(`REG_IRQ_STAT, {31'h0, e}, 34'h300000007, "irq status");
		axi_wr(`REG_IRQ_CLR, 32'h7);
	endtask : irq_take

	task automatic irq_is(input logic e);
		@(negedge mclk);
		chk("irq", {33'h0, e}, {33'h0, irq});
	endtask : irq_is

	// monitor: oldest note against each accepted read answer
	always @(negedge mclk) begin
		if (s_axi_bvalid && s_axi_bready) begin
			chk("write response", 34'h0, {32'h0, s_axi_bresp});
		end
		if (s_axi_rvalid && s_axi_rready && q.size() > 0) begin
			if (q[0].m != '0) chk(q[0].nm, q[0].e, {s_axi_rresp, s_axi_rdata} & q[0].m);
			void'(q.pop_front());
		end
	end

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		sys_rst = 1'b1;
		lfsr = 32'hD09A;
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		axi_rd(`REG_STATUS, '0, 34'h300000001, "status at reset");
		axi_rd(`REG_IRQ_EN, '0, 34'h300000007, "irq enable at reset");
		axi_rd(8'h20, 34'h200000000, 34'h3FFFFFFFF, "unmapped");
		axi_wr(`REG_IRQ_EN, 32'h7);
		$display("test registers done");
		lfsr = lfsr_next(lfsr_next(lfsr));
		d = {lfsr[15:8], lfsr[7:0] & 8'hDE};
		link_wr(12'h6A5, 16'h00A0, 32'h2);
		link_wr(12'h6A5, d, 32'h2);
		link_rd(12'hC33, 16'hFFFF, 16'hFFFF, "idle bank");
		link_rd(12'h6A5, {8'h0, ~d[7], 7'h0}, 16'h00A8, "program status");
		do_op(32'h3);
		irq_is(1'b1);
		axi_wr(`REG_IRQ_EN, 32'h0);
		irq_is(1'b0);
		axi_wr(`REG_IRQ_EN, 32'h7);
		irq_take(3'h1);
		irq_is(1'b0);
		link_rd(12'h6A5, d, 16'hFFFF, "programmed word");
		$display("test program done");
		link_wr(12'h6A5, 16'h00A0, 32'h2);
		link_wr(12'h6A5, 16'hFFFF, 32'h2);
		do_op(32'h3);
		irq_take(3'h3);
		link_wr(12'h6A5, 16'h00F0, 32'h2);
		link_rd(12'h6A5, d, 16'hFFFF, "word after timeout");
		$display("test timeout done");
		link_wr(12'h500, 16'h00A0, 32'h2);
		link_wr(12'h500, d, 32'h2);
		do_op(32'h3);
		link_wr(12'h400, 16'h0030, 32'h2);
		link_wr(12'h500, 16'h0030, 32'h4);
		irq_take(3'h1);
		repeat (250) @(posedge mclk);
		link_wr(12'h700, 16'h0030, 32'h4);
		irq_take(3'h4);
		link_rd(12'h400, 16'h0008, 16'h00A8, "erase status");
		link_wr(12'h400, 16'h00B0, 32'h2);
		link_rd(12'h400, 16'h0080, 16'h00A8, "suspended sector");
		link_rd(12'h6A5, d, 16'hFFFF, "other sector");
		link_wr(12'h6A6, 16'h00A0, 32'h2);
		link_wr(12'h6A6, d, 32'h2);
		link_rd(12'h6A6, {8'h0, ~d[7], 7'h0}, 16'h00A0, "suspend program status");
		do_op(32'h3);
		link_rd(12'h6A6, d, 16'hFFFF, "suspend programmed word");
		link_wr(12'h400, 16'h003A, 32'h2);
		do_op(32'h3);
		irq_take(3'h1);
		link_rd(12'h500, 16'hFFFF, 16'hFFFF, "erased word");
		$display("test erase done");
		link_wr(12'h6A5, 16'h0030, 32'h2);
		axi_wr(`REG_CTRL, 32'h100);
		axi_wr(`REG_CTRL, 32'h0);
		link_rd(12'h6A5, d, 16'hFFFF, "word after link reset");
		$display("test link reset done");
		print_verdict();
	end
endmodule : tb_top
